//--- hdl/dwt_pkg.sv
`default_nettype none
package dwt_pkg;
	// register offsets
	localparam logic [7:0] OFS_SEQ_CTRL = 8'hf0;
	localparam logic [7:0] OFS_ONE_MODE = 8'hf5;
	localparam logic [7:0] OFS_ONE_COUNT = 8'hf6;
	localparam logic [7:0] OFS_ONE_STATUS = 8'hf7;
	localparam logic [7:0] OFS_TWO_MODE = 8'hf8;
	localparam logic [7:0] OFS_TWO_COUNT = 8'hf9;
	localparam logic [7:0] OFS_TWO_STATUS = 8'hfa;
	localparam logic [7:0] OFS_GPIO_SEL_LO = 8'hfb;
	localparam logic [7:0] OFS_GPIO_SEL_HI = 8'hfc;
	// field positions
	localparam int BIT_HOLD_LEVEL = 0;
	localparam int BIT_UNIT_MIN = 3;
	localparam int BIT_EXPIRED = 4;
	localparam int BIT_SEQ_LO = 0;
	localparam int BIT_SEQ_HI = 7;
	// reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] ZERO_COUNT = 8'h00;
	localparam logic [7:0] ONE_COUNT = 8'h01;
	localparam int NUM_GPIO = 10;
	// timing in own units
	localparam int CLK_HZ = 10_000_000;
	localparam int PULSE_MS = 100;
	localparam int RESUME_MS = 250;
	localparam int UNIT_SEC = 1;
	localparam int UNIT_MIN_SEC = 60;
	localparam int MS_PER_SEC = 1000;
	localparam int PULSE_CYC = PULSE_MS * (CLK_HZ / MS_PER_SEC);
	localparam int RESUME_CYC = RESUME_MS * (CLK_HZ / MS_PER_SEC);
	localparam int SEC_CYC = UNIT_SEC * CLK_HZ;
	localparam int MIN_CYC = UNIT_MIN_SEC * CLK_HZ;
	// watchdog state, gray along idle -> run -> done
	typedef enum logic [1:0] {
		WD_IDLE = 2'b00,
		WD_RUN = 2'b01,
		WD_DONE = 2'b11
	} dwt_state_type;
endpackage : dwt_pkg
`default_nettype wire

//--- hdl/dwt_timebase.sv
`default_nettype none
// ===========================================================
// tick generator for one watchdog counter
module dwt_timebase #(
	parameter int SEC_CYCLES = dwt_pkg::SEC_CYC,
	parameter int MIN_CYCLES = dwt_pkg::MIN_CYC
) (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic restart_in,
	input wire logic unit_min_in,
	output logic tick_out
);
	logic [31:0] cnt_ff;
	logic [31:0] limit;

	// the period restarts with every load so the first tick is a full unit
	assign limit = unit_min_in ? 32'(MIN_CYCLES - 1) : 32'(SEC_CYCLES - 1);
	assign tick_out = (cnt_ff >= limit) && !restart_in;

	// free count, cleared on load or tick
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in || restart_in || tick_out) begin
			cnt_ff <= 32'h0000_0000;
		end else begin
			cnt_ff <= cnt_ff + 32'h0000_0001;
		end
	end
endmodule : dwt_timebase
`default_nettype wire

//--- hdl/dwt_lowpulse.sv
`default_nettype none
// ===========================================================
// low pulse of fixed length, or held until released
module dwt_lowpulse #(
	parameter int LEN = dwt_pkg::PULSE_CYC
) (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic trig_in,
	input wire logic hold_in,
	input wire logic release_in,
	output logic active_out
);
	logic [31:0] cnt_ff;
	logic held_ff;

	assign active_out = held_ff || (cnt_ff != 32'h0000_0000);

	// a new trigger restarts the pulse length
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			cnt_ff <= 32'h0000_0000;
		end else if (trig_in && !hold_in) begin
			cnt_ff <= 32'(LEN);
		end else if (cnt_ff != 32'h0000_0000) begin
			cnt_ff <= cnt_ff - 32'h0000_0001;
		end
	end

	// held level stays until release_in (a flag clear by software, bus reset or power-good) or reset releases it
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			held_ff <= 1'b0;
		end else if (trig_in && hold_in) begin
			held_ff <= 1'b1;
		end else if (release_in) begin
			held_ff <= 1'b0;
		end
	end
endmodule : dwt_lowpulse
`default_nettype wire

//--- hdl/dwt_top.sv
// Contract
// - the first watchdog is an 8-bit down-counter with mode and status.
// - bit 3 of the first mode register picks the counting unit.
// - writing zero to the first count register disables that watchdog.
// - a non-zero count write loads the counter and starts it at once.
// - at zero the first counter stops and sets status bit 4.
// - writing zero to an expiry flag bit clears it.
// - bus reset or power-good assertion also clears the expiry flags.
// - first expiry drives power-good, reset out and gpio low, pulse or level.
// - first expiry pulses the resume reset low for about 250 ms; the code skips the pulse when sequencing bit 7 or 0 is set.
// - sequencing bits 7 and 0 at zero give the normal sequence.
// - each gpio timeout pin is enabled by its own select bit.
// - timeout goes to bits 0,4 of groups 0,2,4,6, 3 of 3 and 0 of 7.
// - the second watchdog is 8-bit with a unit bit in its mode register.
// - the second count register disables on zero and starts on non-zero.
// - second expiry drives only power-good and reset out low.
// - the second counter stops at zero and sets its status bit 4.
`default_nettype none
// ===========================================================
// dual watchdog timer
module dwt_top #(
	parameter int SEC_CYCLES = dwt_pkg::SEC_CYC,
	parameter int MIN_CYCLES = dwt_pkg::MIN_CYC,
	parameter int PULSE_CYCLES = dwt_pkg::PULSE_CYC,
	parameter int RESUME_CYCLES = dwt_pkg::RESUME_CYC
) (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	input wire logic bus_reset_n_in,
	input wire logic power_good_in,
	output logic power_good_output_n_out,
	output logic reset_connector_out_n_out,
	output logic resume_reset_out_n_out,
	output logic [dwt_pkg::NUM_GPIO-1:0] gpio_timeout_n_out,
	output logic [1:0] watchdog_expiry_output_out
);
	// ===========================================================
	// pin synchronisers
	logic [2:0] bus_rst_sync_ff;
	logic [2:0] pg_sync_ff;
	logic bus_rst_level_ff;
	logic pg_level_ff;
	logic pg_rise;
	logic bus_reset_act;

	// three stages; a change counts once stages two and three agree
	// both chains reset to the idle level of their pin, so leaving reset
	// with the system up gives no false bus reset or power-good edge
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			bus_rst_sync_ff <= 3'b111;
		end else begin
			bus_rst_sync_ff <= {bus_rst_sync_ff[1:0], bus_reset_n_in};
		end
	end

	// power-good chain, same depth as the bus reset chain
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			pg_sync_ff <= 3'b111;
		end else begin
			pg_sync_ff <= {pg_sync_ff[1:0], power_good_in};
		end
	end

	// filtered bus reset level; a one-cycle glitch never gets through
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			bus_rst_level_ff <= 1'b1;
		end else if (bus_rst_sync_ff[1] == bus_rst_sync_ff[2]) begin
			bus_rst_level_ff <= bus_rst_sync_ff[2];
		end
	end

	// filtered power-good level, the reference for its rising edge
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			pg_level_ff <= 1'b1;
		end else if (pg_sync_ff[1] == pg_sync_ff[2]) begin
			pg_level_ff <= pg_sync_ff[2];
		end
	end

	assign bus_reset_act = !bus_rst_level_ff;
	// power-good assertion is its rising edge after filtering
	assign pg_rise = (pg_sync_ff[1] == pg_sync_ff[2]) && pg_sync_ff[2] &&
		!pg_level_ff;

	// ===========================================================
	// registers
	logic [7:0] seq_ctrl_ff;
	logic [7:0] gpio_sel_lo_ff;
	logic [1:0] gpio_sel_hi_ff;
	logic [7:0] mode_ff [2];
	logic [7:0] count_ff [2];
	logic [1:0] expired_ff;
	dwt_pkg::dwt_state_type state_ff [2];
	logic [1:0] count_wr;
	logic [1:0] status_wr;
	logic [1:0] mode_wr;
	logic [1:0] tick;
	logic [1:0] expire_evt;
	logic [1:0] flag_clear;
	logic [1:0] pulse_act;
	logic resume_act;
	logic seq_normal;

	localparam logic [7:0] MODE_OFS [2] = '{dwt_pkg::OFS_ONE_MODE,
		dwt_pkg::OFS_TWO_MODE};
	localparam logic [7:0] COUNT_OFS [2] = '{dwt_pkg::OFS_ONE_COUNT,
		dwt_pkg::OFS_TWO_COUNT};
	localparam logic [7:0] STATUS_OFS [2] = '{dwt_pkg::OFS_ONE_STATUS,
		dwt_pkg::OFS_TWO_STATUS};

	// sequencing control, kept through a bus reset like the other settings
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			seq_ctrl_ff <= dwt_pkg::RST_BYTE;
		end else if (reg_wr_in) begin
			if (reg_addr_in == dwt_pkg::OFS_SEQ_CTRL) begin
				seq_ctrl_ff <= reg_wdata_in;
			end
		end
	end

	// two bytes hold the ten pin enables; the upper six bits of the
	// second byte are not stored and read back as zero
	// per-pin select
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			gpio_sel_lo_ff <= dwt_pkg::RST_BYTE;
			gpio_sel_hi_ff <= 2'b00;
		end else if (reg_wr_in) begin
			if (reg_addr_in == dwt_pkg::OFS_GPIO_SEL_LO) begin
				gpio_sel_lo_ff <= reg_wdata_in;
			end
			if (reg_addr_in == dwt_pkg::OFS_GPIO_SEL_HI) begin
				gpio_sel_hi_ff <= reg_wdata_in[1:0];
			end
		end
	end

	// ===========================================================
	// the two watchdog channels
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_wd
			assign mode_wr[ch] = reg_wr_in && (reg_addr_in == MODE_OFS[ch]);
			assign count_wr[ch] = reg_wr_in && (reg_addr_in == COUNT_OFS[ch]);
			assign status_wr[ch] = reg_wr_in &&
				(reg_addr_in == STATUS_OFS[ch]);

			// mode register
			always_ff @(posedge core_clk_in) begin
				if (sys_rst_in) begin
					mode_ff[ch] <= dwt_pkg::RST_BYTE;
				end else if (mode_wr[ch]) begin
					mode_ff[ch] <= reg_wdata_in;
				end
			end

			dwt_timebase #(
				.SEC_CYCLES(SEC_CYCLES),
				.MIN_CYCLES(MIN_CYCLES)
			) u_tb (
				.core_clk_in(core_clk_in),
				.sys_rst_in(sys_rst_in),
				.restart_in(count_wr[ch] || state_ff[ch] != dwt_pkg::WD_RUN),
				.unit_min_in(mode_ff[ch][dwt_pkg::BIT_UNIT_MIN]),
				.tick_out(tick[ch])
			);

			// expiry when the last unit elapses
			assign expire_evt[ch] = (state_ff[ch] == dwt_pkg::WD_RUN) &&
				tick[ch] && (count_ff[ch] == dwt_pkg::ONE_COUNT) &&
				!count_wr[ch];

			always_ff @(posedge core_clk_in) begin
				if (sys_rst_in || bus_reset_act) begin
					count_ff[ch] <= dwt_pkg::ZERO_COUNT;
					state_ff[ch] <= dwt_pkg::WD_IDLE;
				end else if (count_wr[ch]) begin
					count_ff[ch] <= reg_wdata_in;
					if (reg_wdata_in == dwt_pkg::ZERO_COUNT) begin
						state_ff[ch] <= dwt_pkg::WD_IDLE;
					end else begin
						state_ff[ch] <= dwt_pkg::WD_RUN;
					end
				end else begin
					case (state_ff[ch])
						dwt_pkg::WD_RUN: begin
							if (tick[ch]) begin
								count_ff[ch] <= count_ff[ch] - dwt_pkg::ONE_COUNT;
							end
							if (expire_evt[ch]) begin
								state_ff[ch] <= dwt_pkg::WD_DONE;
							end
						end
						dwt_pkg::WD_DONE: begin
							state_ff[ch] <= dwt_pkg::WD_DONE;
						end
						default: begin
							state_ff[ch] <= dwt_pkg::WD_IDLE;
						end
					endcase
				end
			end

			// clears by zero write, bus reset, power-good
			assign flag_clear[ch] = (status_wr[ch] &&
				!reg_wdata_in[dwt_pkg::BIT_EXPIRED]) || bus_reset_act || pg_rise;

			// sticky flag; a fresh expiry wins over a clear
			always_ff @(posedge core_clk_in) begin
				if (sys_rst_in) begin
					expired_ff[ch] <= 1'b0;
				end else if (expire_evt[ch]) begin
					expired_ff[ch] <= 1'b1;
				end else if (flag_clear[ch]) begin
					expired_ff[ch] <= 1'b0;
				end
			end

			// pulse or held low, held until the flag clears
			dwt_lowpulse #(
				.LEN(PULSE_CYCLES)
			) u_pulse (
				.core_clk_in(core_clk_in),
				.sys_rst_in(sys_rst_in),
				.trig_in(expire_evt[ch]),
				.hold_in(mode_ff[ch][dwt_pkg::BIT_HOLD_LEVEL]),
				.release_in(flag_clear[ch]),
				.active_out(pulse_act[ch])
			);
		end
	endgenerate

	// ===========================================================
	// resume reset, first watchdog only
	// normal sequence only when both bits are zero
	assign seq_normal = !seq_ctrl_ff[dwt_pkg::BIT_SEQ_HI] &&
		!seq_ctrl_ff[dwt_pkg::BIT_SEQ_LO];

	// about 250 ms low; skipped in the alternative sequence
	dwt_lowpulse #(
		.LEN(RESUME_CYCLES)
	) u_resume (
		.core_clk_in(core_clk_in),
		.sys_rst_in(sys_rst_in),
		.trig_in(expire_evt[0] && seq_normal),
		.hold_in(1'b0),
		.release_in(1'b0),
		.active_out(resume_act)
	);

	// ===========================================================
	// outputs, all from flip-flops
	logic pg_n_ff;
	logic rcon_n_ff;
	logic rsm_n_ff;
	logic [dwt_pkg::NUM_GPIO-1:0] gpio_n_ff;
	logic [dwt_pkg::NUM_GPIO-1:0] gpio_sel;

	// pins: g0 b0,b4 g2 b0,b4 g4 b0,b4 g6 b0,b4 g3 b3 g7 b0
	assign gpio_sel = {gpio_sel_hi_ff, gpio_sel_lo_ff};

	// both pins share one source so they can never disagree
	// either watchdog pulls power-good and reset out
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			pg_n_ff <= 1'b1;
			rcon_n_ff <= 1'b1;
		end else begin
			pg_n_ff <= !(|pulse_act);
			rcon_n_ff <= !(|pulse_act);
		end
	end

	// resume reset follows the first watchdog only
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			rsm_n_ff <= 1'b1;
		end else begin
			rsm_n_ff <= !resume_act;
		end
	end

	// only enabled pins follow the first watchdog
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			gpio_n_ff <= '1;
		end else begin
			gpio_n_ff <= ~(gpio_sel & {dwt_pkg::NUM_GPIO{pulse_act[0]}});
		end
	end

	assign power_good_output_n_out = pg_n_ff;
	assign reset_connector_out_n_out = rcon_n_ff;
	assign resume_reset_out_n_out = rsm_n_ff;
	assign gpio_timeout_n_out = gpio_n_ff;
	assign watchdog_expiry_output_out = expired_ff;

	// ===========================================================
	// register read port; unmapped offsets read zero
	logic [7:0] rdata_ff;
	logic [7:0] nxt_rdata;

	always_comb begin
		nxt_rdata = dwt_pkg::RST_BYTE;
		case (reg_addr_in)
			dwt_pkg::OFS_SEQ_CTRL: nxt_rdata = seq_ctrl_ff;
			dwt_pkg::OFS_ONE_MODE: nxt_rdata = mode_ff[0];
			dwt_pkg::OFS_ONE_COUNT: nxt_rdata = count_ff[0];
			dwt_pkg::OFS_ONE_STATUS:
				nxt_rdata[dwt_pkg::BIT_EXPIRED] = expired_ff[0];
			dwt_pkg::OFS_TWO_MODE: nxt_rdata = mode_ff[1];
			dwt_pkg::OFS_TWO_COUNT: nxt_rdata = count_ff[1];
			dwt_pkg::OFS_TWO_STATUS:
				nxt_rdata[dwt_pkg::BIT_EXPIRED] = expired_ff[1];
			dwt_pkg::OFS_GPIO_SEL_LO: nxt_rdata = gpio_sel_lo_ff;
			dwt_pkg::OFS_GPIO_SEL_HI: nxt_rdata = {6'b00_0000, gpio_sel_hi_ff};
			default: nxt_rdata = dwt_pkg::RST_BYTE;
		endcase
	end

	// read data captured on the read strobe, held until the next
	always_ff @(posedge core_clk_in) begin
		if (sys_rst_in) begin
			rdata_ff <= dwt_pkg::RST_BYTE;
		end else if (reg_rd_in) begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata_out = rdata_ff;
endmodule : dwt_top
`default_nettype wire

//--- dv/dwt_checker.sv
`default_nettype none
// ===========================================================
// port checker for the dual watchdog
module dwt_checker (
	input wire logic core_clk_in,
	input wire logic sys_rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic power_good_output_n_out,
	input wire logic reset_connector_out_n_out,
	input wire logic resume_reset_out_n_out,
	input wire logic [dwt_pkg::NUM_GPIO-1:0] gpio_timeout_n_out,
	input wire logic [1:0] watchdog_expiry_output_out
);
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (sys_rst_in);
	// resume reset low for at least eight cycles
	sequence rsm_low_run;
		!resume_reset_out_n_out [*8];
	endsequence
	// ===========================================================
	// expiry outputs
	chk_one_expiry_out: assert property (
		$rose(watchdog_expiry_output_out[0]) |=> !power_good_output_n_out
		&& !reset_connector_out_n_out) else $error("first expiry no output");
	chk_two_expiry_out: assert property (
		$rose(watchdog_expiry_output_out[1]) |=> !power_good_output_n_out
		&& !reset_connector_out_n_out) else $error("second expiry no output");
	chk_pg_rcon_pair: assert property (
		power_good_output_n_out == reset_connector_out_n_out)
		else $error("power good and reset out differ");
	// bounded so a stuck-low resume reset is caught
	chk_rsm_length: assert property (
		$fell(resume_reset_out_n_out) |-> rsm_low_run ##[1:12]
		resume_reset_out_n_out) else $error("resume pulse length wrong");
	chk_rsm_cause: assert property (
		$fell(resume_reset_out_n_out) |-> $past(watchdog_expiry_output_out[0])
		&& !$past(watchdog_expiry_output_out[0], 2))
		else $error("resume pulse without first expiry");
	chk_gpio_cause: assert property (
		$rose(|(~gpio_timeout_n_out)) |-> watchdog_expiry_output_out[0]
		&& !power_good_output_n_out) else $error("gpio low without cause");
	// ===========================================================
	// register port
	chk_flag_clear: assert property (
		reg_wr_in && reg_addr_in == dwt_pkg::OFS_ONE_STATUS
		&& !reg_wdata_in[4] && watchdog_expiry_output_out[0]
		|=> !watchdog_expiry_output_out[0]) else $error("flag not cleared");
	chk_rdata_hold: assert property (
		!reg_rd_in [*3] |-> $stable(reg_rdata_out))
		else $error("read data moved without read");
	chk_unmapped_read: assert property (
		reg_rd_in && reg_addr_in == 8'h10 |=> ##[0:1] reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
endmodule : dwt_checker
bind dwt_top dwt_checker u_dwt_checker (
	.core_clk_in(core_clk_in),
	.sys_rst_in(sys_rst_in),
	.reg_addr_in(reg_addr_in),
	.reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in),
	.reg_wdata_in(reg_wdata_in),
	.reg_rdata_out(reg_rdata_out),
	.power_good_output_n_out(power_good_output_n_out),
	.reset_connector_out_n_out(reset_connector_out_n_out),
	.resume_reset_out_n_out(resume_reset_out_n_out),
	.gpio_timeout_n_out(gpio_timeout_n_out),
	.watchdog_expiry_output_out(watchdog_expiry_output_out)
);
`default_nettype wire

//--- dv/dwt_sys_model.sv
`default_nettype none
// ===========================================================
// system side: bus reset and power-good source
module dwt_sys_model (
	input wire logic core_clk_in,
	output logic bus_reset_n_out,
	output logic power_good_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// system up and bus out of reset at start
	initial begin
		bus_reset_n_out = 1'b1;
		power_good_out = 1'b1;
	end
	// held six cycles so the input filter surely sees it
	task automatic pulse_bus_reset();
		bus_reset_n_out = 1'b0;
		repeat (6) @(posedge core_clk_in);
		#10;
		bus_reset_n_out = 1'b1;
		repeat (6) @(posedge core_clk_in);
		#10;
	endtask : pulse_bus_reset
	// power drop, then power good asserts again
	task automatic power_cycle();
		power_good_out = 1'b0;
		repeat (6) @(posedge core_clk_in);
		#10;
		power_good_out = 1'b1;
		repeat (6) @(posedge core_clk_in);
		#10;
	endtask : power_cycle
endmodule : dwt_sys_model
`default_nettype wire

//--- dv/dwt_tb.sv
`default_nettype none
// ===========================================================
// testbench
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SEC = 20;
	localparam int MIN = 40;
	localparam int PLS = 10;
	typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} dwt_row_type;
	logic core_clk_in, sys_rst_in, reg_wr_in, reg_rd_in;
	logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rv;
	logic bus_rst_n, pg_in, pg_n, rcon_n, rsm_n;
	logic [9:0] gpio_n;
	logic [1:0] flags;
	logic [15:0] n;
	int bad_count = 0;
	int compares = 0;
	int cycles = 0;
	dwt_row_type rows [8] = '{'{8'hf0, 8'h81, 8'h81}, '{8'hf5, 8'h09, 8'h09},
		'{8'hf8, 8'h09, 8'h09}, '{8'hfb, 8'ha5, 8'ha5}, '{8'hfc, 8'h02, 8'h02},
		'{8'hf7, 8'hff, 8'h00}, '{8'hfa, 8'hff, 8'h00}, '{8'h10, 8'h5a, 8'h00}};
	dwt_top #(.SEC_CYCLES(SEC), .MIN_CYCLES(MIN), .PULSE_CYCLES(PLS),
		.RESUME_CYCLES(15)) u_dwt_top (
		.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
		.reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in),
		.reg_rdata_out(reg_rdata_out), .bus_reset_n_in(bus_rst_n),
		.power_good_in(pg_in), .power_good_output_n_out(pg_n),
		.reset_connector_out_n_out(rcon_n), .resume_reset_out_n_out(rsm_n),
		.gpio_timeout_n_out(gpio_n), .watchdog_expiry_output_out(flags));
	dwt_sys_model u_dwt_sys_model (.core_clk_in(core_clk_in),
		.bus_reset_n_out(bus_rst_n), .power_good_out(pg_in));
	always #50 core_clk_in = ~core_clk_in;
	// cut a hang short; the run needs well under a thousand cycles
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 3000) begin
			bad_count++;
			results();
		end
	end
	task automatic check(input string nm, input logic [9:0] s, e);
		compares++;
		if (s !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask : check
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk_in);
		#10;
	endtask : cyc
	// an edge passes after each write so the strobe is never set twice
	// in one time step by back-to-back writes
	task automatic wr(input logic [7:0] a, d);
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		cyc(1);
		reg_wr_in = 1'b0;
		cyc(1);
	endtask : wr
	// data is taken one cycle after the strobe, where it stands
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		reg_addr_in = a;
		reg_rd_in = 1'b1;
		cyc(1);
		reg_rd_in = 1'b0;
		cyc(1);
		d = reg_rdata_out;
	endtask : rd
	task automatic wait_flag(input int b);
		n = 16'h0000;
		while (flags[b] !== 1'b1 && n < 16'h0100) begin
			cyc(1);
			n++;
		end
	endtask : wait_flag
	task automatic results();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	initial begin
		core_clk_in = 1'b0;
		sys_rst_in = 1'b1;
		reg_wr_in = 1'b0;
		reg_rd_in = 1'b0;
		reg_addr_in = 8'h00;
		reg_wdata_in = 8'h00;
		cyc(2);
		sys_rst_in = 1'b0;
		check("outs", {pg_n, rcon_n, rsm_n, 7'h7f & gpio_n[6:0]}, 10'h3ff);
		// reset value, then write and read back, per register
		foreach (rows[i]) begin
			rd(rows[i].a, rv);
			check("reset", 10'(rv), 10'h000);
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rv);
			check("readback", 10'(rv), 10'(rows[i].e));
		end
		wr(8'hf0, 8'h00);
		wr(8'hf5, 8'h00);
		wr(8'hf8, 8'h00);
		wr(8'hfb, 8'h05);
		// first watchdog, seconds, pulse mode
		wr(8'hf6, 8'h02);
		rd(8'hf6, rv);
		check("count", 10'(rv), 10'h002);
		wait_flag(0);
		check("wd1 time", 10'(n >= 2 * SEC - 3 && n <= 2 * SEC), 10'h001);
		cyc(1);
		check("wd1 outs", {pg_n, rcon_n, rsm_n, 7'h00}, 10'h000);
		check("gpio", gpio_n, 10'h1fa);
		rd(8'hf7, rv);
		check("status", 10'(rv), 10'h010);
		rd(8'hf6, rv);
		check("stopped", 10'(rv), 10'h000);
		cyc(7);
		check("pulse end", {pg_n, rsm_n, 8'h00}, 10'h200);
		cyc(5);
		check("rsm end", 10'(rsm_n), 10'h001);
		wr(8'hf7, 8'h00);
		check("clear", 10'(flags), 10'h000);
		// minutes unit, held level, resume pulse suppressed
		wr(8'hf0, 8'h01);
		wr(8'hf5, 8'h09);
		wr(8'hf6, 8'h01);
		wait_flag(0);
		check("min time", 10'(n >= MIN - 1 && n <= MIN + 1), 10'h001);
		cyc(30);
		check("level", {pg_n, rsm_n, 8'h00}, 10'h100);
		u_dwt_sys_model.power_cycle();
		check("pg clear", {pg_n, 7'h00, flags}, 10'h200);
		// second watchdog touches neither gpio nor resume reset
		wr(8'hf0, 8'h00);
		wr(8'hf9, 8'h01);
		wait_flag(1);
		check("wd2 time", 10'(n >= SEC - 1 && n <= SEC + 1), 10'h001);
		cyc(1);
		check("wd2 outs", {pg_n, rcon_n, rsm_n, 7'h00}, 10'h080);
		check("wd2 gpio", gpio_n, 10'h3ff);
		rd(8'hfa, rv);
		check("status2", 10'(rv), 10'h010);
		u_dwt_sys_model.pulse_bus_reset();
		check("bus clear", 10'(flags), 10'h000);
		// second watchdog in minutes, then its flag cleared by a zero write
		wr(8'hf8, 8'h08);
		wr(8'hf9, 8'h01);
		wait_flag(1);
		check("wd2 min", 10'(n >= MIN - 1 && n <= MIN + 1), 10'h001);
		wr(8'hfa, 8'h00);
		check("clear2", 10'(flags), 10'h000);
		// zero write stops a running count well before it could expire
		wr(8'hf6, 8'h01);
		cyc(10);
		wr(8'hf6, 8'h00);
		cyc(80);
		check("disabled", 10'(flags), 10'h000);
		results();
	end
endmodule : testbench
`default_nettype wire
